// >>> pkg/xm_pkg.sv
// Shared constants, types and helpers of the MAC-facing data interface
package xm_pkg;

    ////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int LINK_PERIOD_NS = 160;
    localparam int LINK_CYC = LINK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int LINK_HALF_CYC = LINK_CYC / 2;
    localparam logic [2:0] LINK_LAST = 3'(LINK_CYC - 1);
    localparam logic [2:0] LINK_HALF_LAST = 3'(LINK_HALF_CYC - 1);
    localparam logic [1:0] SER_BIT_LAST = 2'h3;
    localparam logic [1:0] SER_BIT_MID = 2'h1;
    localparam logic [3:0] SER_FRAME_BITS = 4'h9;
    localparam logic [2:0] SER_WORD_LAST = 3'h6;

    ////////////////////////////////////////////////////////////
    // Device configuration register
    localparam logic [15:0] SMLC_ADDR = 16'h0608;
    localparam logic [15:0] SMLC_RESET = 16'h0001;
    localparam int SMLC_AN_BIT = 0;

    ////////////////////////////////////////////////////////////
    // Controller registers
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] TXSYM_OFF = 12'h004;
    localparam logic [11:0] STATUS_OFF = 12'h008;
    localparam int CTRL_SERIAL_BIT = 0;
    localparam logic CTRL_RESET = 1'h0;

    ////////////////////////////////////////////////////////////
    // Codes
    localparam logic [3:0] FALSE_CARRIER_NIB = 4'he;
    localparam logic [1:0] SPEED_125M = 2'h2;
    localparam logic [1:0] SPEED_RSVD = 2'h3;

    // Code is {rising-edge control, falling-edge control}
    typedef enum logic [1:0] {
        CODE_IDLE = 2'h0,
        CODE_RSVD = 2'h1,
        CODE_DATA = 2'h2,
        CODE_ERR = 2'h3
    } xm_code_t;

    typedef enum logic [1:0] {
        SRX_IDLE = 2'h0,
        SRX_START = 2'h1,
        SRX_DATA = 2'h3,
        SRX_STOP = 2'h2
    } xm_srx_st_t;

    typedef struct packed {
        logic [25:0] zero;
        logic [1:0] code;
        logic [3:0] data;
    } xm_txsym_t;

    typedef struct packed {
        logic [7:0] zero_hi;
        logic [7:0] count;
        logic zero_mid;
        logic lc_seen;
        logic [3:0] inband;
        logic [1:0] code;
        logic [3:0] data;
        logic [2:0] zero_lo;
        logic pend;
    } xm_status_t;

    // Serial word: {link-code flag, code, nibble}
    function automatic logic [6:0] ser_word(input logic lc, input logic [1:0] code, input logic [3:0] d);
        return {lc, code, d};
    endfunction

    // Reserved transmit code is never passed on
    function automatic logic [1:0] tx_fix(input logic [1:0] code);
        return (code == CODE_RSVD) ? CODE_IDLE : code;
    endfunction

endpackage

// >>> pkg/xm_link_if.sv
// Link between controller end and device end
interface xm_link_if;
    logic tx_clk;
    logic tx_ctl;
    logic [3:0] tx_d;
    logic rx_clk;
    logic rx_ctl;
    logic [3:0] rx_d;
    logic stx_p;
    logic stx_n;
    logic srx_p;
    logic srx_n;
    modport mac (output tx_clk, tx_ctl, tx_d, stx_p, stx_n, input rx_clk, rx_ctl, rx_d, srx_p, srx_n);
    modport phy (input tx_clk, tx_ctl, tx_d, stx_p, stx_n, output rx_clk, rx_ctl, rx_d, srx_p, srx_n);
endinterface

// >>> src/xm_serdes.sv
// Serial word transmitter and receiver with per-frame clock recovery
module xm_serdes (
    // Clock and reset
    input logic pclk,
    input logic presetn,
    // Enable
    input logic en,
    // Transmit
    input logic tx_load,
    input logic [6:0] tx_word,
    output logic tx_ready,
    output logic ser_p,
    output logic ser_n,
    // Receive
    input logic ser_in,
    output logic rx_valid,
    output logic [6:0] rx_word
);
    ////////////////////////////////////////////////////////////
    // Transmitter
    logic [8:0] tsh_q;
    logic [3:0] tbits_q;
    logic [1:0] tcyc_q;
    logic tline_q;
    assign tx_ready = en && tbits_q == 4'h0;
    assign ser_p = tline_q;
    assign ser_n = en && !tline_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tsh_q <= '0;
            tbits_q <= '0;
            tcyc_q <= '0;
            tline_q <= 1'b0;
        end else if (!en) begin
            tbits_q <= '0;
            tcyc_q <= '0;
            tline_q <= 1'b0;
        end else if (tbits_q == 4'h0) begin
            tline_q <= 1'b1;
            tcyc_q <= '0;
            if (tx_load) begin
                tsh_q <= {1'b1, tx_word, 1'b0};
                tbits_q <= xm_pkg::SER_FRAME_BITS;
            end
        end else begin
            tcyc_q <= tcyc_q + 2'h1;
            if (tcyc_q == 2'h0) begin
                tline_q <= tsh_q[0];
                tsh_q <= {1'b1, tsh_q[8:1]};
            end
            if (tcyc_q == xm_pkg::SER_BIT_LAST) begin
                tbits_q <= tbits_q - 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////
    // Receiver
    xm_pkg::xm_srx_st_t st_q;
    logic s1_q, s2_q, s3_q;
    logic [1:0] rcyc_q;
    logic [2:0] rbit_q;
    logic [6:0] rsh_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= ser_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= xm_pkg::SRX_IDLE;
            rcyc_q <= '0;
            rbit_q <= '0;
            rsh_q <= '0;
            rx_valid <= 1'b0;
            rx_word <= '0;
        end else begin
            rx_valid <= 1'b0;
            rcyc_q <= rcyc_q + 2'h1;
            case (st_q)
                xm_pkg::SRX_IDLE: begin
                    rcyc_q <= '0;
                    if (en && s3_q && !s2_q) begin
                        st_q <= xm_pkg::SRX_START;
                    end
                end
                xm_pkg::SRX_START: begin
                    if (rcyc_q == xm_pkg::SER_BIT_MID) begin
                        rcyc_q <= '0;
                        rbit_q <= '0;
                        st_q <= s2_q ? xm_pkg::SRX_IDLE : xm_pkg::SRX_DATA;
                    end
                end
                xm_pkg::SRX_DATA: begin
                    if (rcyc_q == xm_pkg::SER_BIT_LAST) begin
                        rsh_q <= {s2_q, rsh_q[6:1]};
                        rbit_q <= rbit_q + 3'h1;
                        if (rbit_q == xm_pkg::SER_WORD_LAST) begin
                            st_q <= xm_pkg::SRX_STOP;
                        end
                    end
                end
                xm_pkg::SRX_STOP: begin
                    if (rcyc_q == xm_pkg::SER_BIT_LAST) begin
                        rx_valid <= s2_q && en;
                        rx_word <= rsh_q;
                        st_q <= xm_pkg::SRX_IDLE;
                    end
                end
                default: begin
                    st_q <= xm_pkg::SRX_IDLE;
                end
            endcase
        end
    end
endmodule

// >>> src/xm_phy_end.sv
// Device end of the MAC-facing data interface
//
// Decided for this implementation: a simple select/write register port, not APB.
module xm_phy_end (
    // Clock and reset
    input logic pclk,
    input logic presetn,
    // MAC side
    xm_link_if.phy link,
    // Mode and line status
    input logic mode_serial,
    input logic link_up,
    input logic full_duplex,
    input logic [1:0] line_speed,
    // Line receive stream
    input logic [1:0] line_rx_code,
    input logic [3:0] line_rx_data,
    // Line transmit stream
    output logic tx_sym_valid,
    output logic [1:0] tx_sym_code,
    output logic [3:0] tx_sym_data,
    // Register port
    input logic reg_sel,
    input logic reg_wr,
    input logic [15:0] reg_addr,
    input logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata
);
    ////////////////////////////////////////////////////////////
    // Configuration register
    logic [15:0] cfg_q;
    logic an_en;
    logic rgmii_on;
    logic ser_on;
    logic cfg_hit;

    assign cfg_hit = reg_sel && reg_addr == xm_pkg::SMLC_ADDR;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= xm_pkg::SMLC_RESET;
        end else if (cfg_hit && reg_wr) begin
            cfg_q <= reg_wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reg_rdata <= '0;
        end else if (reg_sel && !reg_wr) begin
            reg_rdata <= cfg_hit ? cfg_q : '0;
        end
    end

    assign an_en = cfg_q[xm_pkg::SMLC_AN_BIT];
    assign rgmii_on = !mode_serial;
    assign ser_on = mode_serial;

    ////////////////////////////////////////////////////////////
    // Status nibble and receive shaping
    logic [1:0] speed_ok;
    logic [3:0] status_nib;
    logic [3:0] rx_data;

    assign speed_ok = (line_speed == xm_pkg::SPEED_RSVD) ? xm_pkg::SPEED_125M : line_speed;
    assign status_nib = {full_duplex, speed_ok, link_up};

    always_comb begin
        rx_data = line_rx_data;
        case (xm_pkg::xm_code_t'(line_rx_code))
            xm_pkg::CODE_IDLE: begin
                rx_data = status_nib;
            end
            xm_pkg::CODE_RSVD: begin
                rx_data = xm_pkg::FALSE_CARRIER_NIB;
            end
            xm_pkg::CODE_DATA: begin
                rx_data = line_rx_data;
            end
            xm_pkg::CODE_ERR: begin
                rx_data = line_rx_data;
            end
            default: begin
                rx_data = line_rx_data;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////
    // Parallel receive direction: clock, control and nibble out
    logic [2:0] div_q;
    logic rclk_q;
    logic rctl_q;
    logic rneg_q;
    logic [3:0] rd_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= '0;
            rclk_q <= 1'b0;
            rctl_q <= 1'b0;
            rneg_q <= 1'b0;
            rd_q <= '0;
        end else if (!rgmii_on) begin
            div_q <= '0;
            rclk_q <= 1'b0;
            rctl_q <= 1'b0;
            rneg_q <= 1'b0;
            rd_q <= '0;
        end else begin
            div_q <= (div_q == xm_pkg::LINK_LAST) ? 3'h0 : div_q + 3'h1;
            if (div_q == xm_pkg::LINK_LAST) begin
                rclk_q <= 1'b1;
                rctl_q <= line_rx_code[1];
                rneg_q <= line_rx_code[0];
                rd_q <= rx_data;
            end
            if (div_q == xm_pkg::LINK_HALF_LAST) begin
                rclk_q <= 1'b0;
                rctl_q <= rneg_q;
            end
        end
    end

    assign link.rx_clk = rclk_q;
    assign link.rx_ctl = rctl_q;
    assign link.rx_d = rd_q;

    ////////////////////////////////////////////////////////////
    // Parallel transmit direction: sample both clock edges
    logic [5:0] tps1_q;
    logic [5:0] tps2_q;
    logic tprev_q;
    logic tpos_q;
    logic thave_q;
    logic [3:0] td_q;
    logic t_rise;
    logic t_fall;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tps1_q <= '0;
            tps2_q <= '0;
            tprev_q <= 1'b0;
        end else begin
            tps1_q <= {link.tx_clk, link.tx_ctl, link.tx_d};
            tps2_q <= tps1_q;
            tprev_q <= tps2_q[5];
        end
    end

    assign t_rise = tps2_q[5] && !tprev_q;
    assign t_fall = !tps2_q[5] && tprev_q && thave_q && rgmii_on;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tpos_q <= 1'b0;
            td_q <= '0;
            thave_q <= 1'b0;
        end else if (!rgmii_on) begin
            thave_q <= 1'b0;
        end else if (t_rise) begin
            tpos_q <= tps2_q[4];
            td_q <= tps2_q[3:0];
            thave_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////
    // Serial option
    logic ser_ready;
    logic [6:0] ser_tx_word;
    logic srx_valid;
    logic [6:0] srx_word;

    always_comb begin
        ser_tx_word = xm_pkg::ser_word(1'b0, line_rx_code, rx_data);
        if (line_rx_code == xm_pkg::CODE_IDLE) begin
            if (an_en) begin
                ser_tx_word = xm_pkg::ser_word(1'b1, xm_pkg::CODE_IDLE, status_nib);
            end else begin
                ser_tx_word = xm_pkg::ser_word(1'b0, xm_pkg::CODE_IDLE, 4'h0);
            end
        end
    end

    xm_serdes u_serdes (
        .pclk(pclk),
        .presetn(presetn),
        .en(ser_on),
        .tx_load(ser_ready),
        .tx_word(ser_tx_word),
        .tx_ready(ser_ready),
        .ser_p(link.srx_p),
        .ser_n(link.srx_n),
        .ser_in(link.stx_p),
        .rx_valid(srx_valid),
        .rx_word(srx_word)
    );

    ////////////////////////////////////////////////////////////
    // Transmit symbols to the line side
    logic in_valid;
    logic [1:0] in_code;
    logic [3:0] in_data;

    always_comb begin
        in_valid = t_fall;
        in_code = {tpos_q, tps2_q[4]};
        in_data = td_q;
        if (!t_fall && srx_valid && ser_on && !srx_word[6]) begin
            in_valid = 1'b1;
            in_code = srx_word[5:4];
            in_data = srx_word[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_sym_valid <= 1'b0;
            tx_sym_code <= '0;
            tx_sym_data <= '0;
        end else begin
            tx_sym_valid <= in_valid;
            if (in_valid) begin
                tx_sym_code <= xm_pkg::tx_fix(in_code);
                tx_sym_data <= in_data;
            end
        end
    end

endmodule

// >>> src/xm_mac_end.sv
// Controller end of the MAC-facing data interface, APB programmed
module xm_mac_end (
    // Clock and reset
    input logic pclk,
    input logic presetn,
    // APB slave
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device side
    xm_link_if.mac link
);
    ////////////////////////////////////////////////////////////
    // Registers
    logic ctrl_q;
    logic pend_q;
    xm_pkg::xm_txsym_t txs_q;
    xm_pkg::xm_status_t st;
    logic [3:0] inband_q;
    logic [1:0] rcode_q;
    logic [3:0] rdata_q;
    logic [7:0] cnt_q;
    logic lc_q;
    logic take;
    logic wr_ok;

    function automatic logic mapped(input logic [11:0] a);
        return a == xm_pkg::CTRL_OFF || a == xm_pkg::TXSYM_OFF || a == xm_pkg::STATUS_OFF;
    endfunction

    assign pready = !(pwrite && paddr == xm_pkg::TXSYM_OFF && pend_q);
    assign pslverr = psel && penable && !mapped(paddr);
    assign wr_ok = psel && penable && pready && pwrite;
    assign st = '{zero_hi: 8'h00, count: cnt_q, zero_mid: 1'b0, lc_seen: lc_q, inband: inband_q,
                  code: rcode_q, data: rdata_q, zero_lo: 3'h0, pend: pend_q};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                xm_pkg::CTRL_OFF: prdata <= {31'h0000_0000, ctrl_q};
                xm_pkg::TXSYM_OFF: prdata <= txs_q;
                xm_pkg::STATUS_OFF: prdata <= st;
                default: prdata <= '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= xm_pkg::CTRL_RESET;
            txs_q <= '0;
            pend_q <= 1'b0;
        end else begin
            if (take) begin
                pend_q <= 1'b0;
            end
            if (wr_ok && paddr == xm_pkg::CTRL_OFF) begin
                ctrl_q <= pwdata[xm_pkg::CTRL_SERIAL_BIT];
            end
            if (wr_ok && paddr == xm_pkg::TXSYM_OFF) begin
                txs_q <= {26'h000_0000, pwdata[5:0]};
                pend_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////
    // Parallel transmit: clock divider and double-edge control
    logic [2:0] div_q;
    logic tclk_q;
    logic tctl_q;
    logic tneg_q;
    logic [3:0] td_q;
    logic [1:0] tcode;
    logic ser_ready;

    assign tcode = pend_q ? xm_pkg::tx_fix(txs_q.code) : xm_pkg::CODE_IDLE;
    assign take = ctrl_q ? ser_ready && pend_q : div_q == xm_pkg::LINK_LAST && pend_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= '0;
            tclk_q <= 1'b0;
            tctl_q <= 1'b0;
            tneg_q <= 1'b0;
            td_q <= '0;
        end else if (ctrl_q) begin
            div_q <= '0;
            tclk_q <= 1'b0;
            tctl_q <= 1'b0;
            tneg_q <= 1'b0;
            td_q <= '0;
        end else begin
            div_q <= (div_q == xm_pkg::LINK_LAST) ? 3'h0 : div_q + 3'h1;
            if (div_q == xm_pkg::LINK_LAST) begin
                tclk_q <= 1'b1;
                tctl_q <= tcode[1];
                tneg_q <= tcode[0];
                td_q <= pend_q ? txs_q.data : 4'h0;
            end
            if (div_q == xm_pkg::LINK_HALF_LAST) begin
                tclk_q <= 1'b0;
                tctl_q <= tneg_q;
            end
        end
    end

    assign link.tx_clk = tclk_q;
    assign link.tx_ctl = tctl_q;
    assign link.tx_d = td_q;

    ////////////////////////////////////////////////////////////
    // Parallel receive sampling and serial option
    logic [5:0] rs1_q;
    logic [5:0] rs2_q;
    logic rprev_q;
    logic rpos_q;
    logic [3:0] rd_q;
    logic srx_valid;
    logic [6:0] srx_word;
    logic sym;
    logic [1:0] scode;
    logic [3:0] sdata;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rs1_q <= '0;
            rs2_q <= '0;
            rprev_q <= 1'b0;
            rpos_q <= 1'b0;
            rd_q <= '0;
        end else begin
            rs1_q <= {link.rx_clk, link.rx_ctl, link.rx_d};
            rs2_q <= rs1_q;
            rprev_q <= rs2_q[5];
            if (rs2_q[5] && !rprev_q) begin
                rpos_q <= rs2_q[4];
                rd_q <= rs2_q[3:0];
            end
        end
    end

    xm_serdes u_serdes (
        .pclk(pclk),
        .presetn(presetn),
        .en(ctrl_q),
        .tx_load(ser_ready),
        .tx_word(xm_pkg::ser_word(1'b0, tcode, pend_q ? txs_q.data : 4'h0)),
        .tx_ready(ser_ready),
        .ser_p(link.stx_p),
        .ser_n(link.stx_n),
        .ser_in(link.srx_p),
        .rx_valid(srx_valid),
        .rx_word(srx_word)
    );

    always_comb begin
        sym = !ctrl_q && !rs2_q[5] && rprev_q;
        scode = {rpos_q, rs2_q[4]};
        sdata = rd_q;
        if (ctrl_q && srx_valid) begin
            sym = !srx_word[6];
            scode = srx_word[5:4];
            sdata = srx_word[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inband_q <= '0;
            rcode_q <= '0;
            rdata_q <= '0;
            cnt_q <= '0;
            lc_q <= 1'b0;
        end else begin
            if (ctrl_q && srx_valid && srx_word[6]) begin
                inband_q <= srx_word[3:0];
                lc_q <= 1'b1;
            end
            if (sym && scode == xm_pkg::CODE_IDLE && !ctrl_q) begin
                inband_q <= sdata;
            end
            if (sym && scode != xm_pkg::CODE_IDLE) begin
                rcode_q <= scode;
                rdata_q <= sdata;
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end

endmodule

// >>> tb/xm_monitor.sv
// Link protocol checker for both ends
module xm_monitor (
    // Clock and reset
    input logic pclk,
    input logic presetn,
    // Parallel option
    input logic tx_clk,
    input logic tx_ctl,
    input logic [3:0] tx_d,
    input logic rx_clk,
    input logic rx_ctl,
    input logic [3:0] rx_d,
    // Serial option
    input logic stx_p,
    input logic stx_n,
    input logic srx_p,
    input logic srx_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence high_half(logic c); c[*4] ##1 !c; endsequence
    sequence rx_lo_hi; $fell(rx_clk) && rx_ctl && !$past(rx_ctl); endsequence
    sequence rx_lo_lo; $fell(rx_clk) && !rx_ctl && !$past(rx_ctl); endsequence
    ////////
    a_tx_clk_high: assert property ($rose(tx_clk) |-> high_half(tx_clk)) else $error("tx clock half");
    a_rx_clk_high: assert property ($rose(rx_clk) |-> high_half(rx_clk)) else $error("rx clock half");
    a_tx_ctl_half: assert property ($rose(tx_clk) |=> $stable(tx_ctl)[*3]) else $error("tx ctl moved");
    a_rx_d_hold: assert property ($rose(rx_clk) |=> $stable(rx_d)[*3]) else $error("rx nibble moved");
    a_tx_no_rsvd: assert property ($fell(tx_clk) && tx_ctl |-> $past(tx_ctl)) else $error("tx reserved");
    a_rx_fc_nib: assert property (rx_lo_hi |-> rx_d == 4'he) else $error("false carrier nibble");
    a_rx_speed_ok: assert property (rx_lo_lo |-> rx_d[2:1] != 2'h3) else $error("speed reserved");
    a_ser_pair: assert property (!(stx_p && stx_n) && !(srx_p && srx_n)) else $error("pair not split");
    a_one_option: assert property (!((stx_p || stx_n) && tx_clk) && !((srx_p || srx_n) && rx_clk))
        else $error("both options active");
endmodule

// >>> tb/tb_phy_mac_side_xmii.sv
// Testbench joining controller end and device end
module tb_phy_mac_side_xmii;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic mode_serial, link_up, full_duplex, tx_sym_valid, reg_sel, reg_wr;
    logic [1:0] line_speed, line_rx_code, tx_sym_code;
    logic [3:0] line_rx_data, tx_sym_data;
    logic [15:0] reg_addr, reg_wdata, reg_rdata;
    int miscompares, checked;
    xm_link_if link();
    xm_mac_end xm_mac_end_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    xm_phy_end xm_phy_end_i (.pclk(pclk), .presetn(presetn), .link(link), .mode_serial(mode_serial),
        .link_up(link_up), .full_duplex(full_duplex), .line_speed(line_speed), .line_rx_code(line_rx_code),
        .line_rx_data(line_rx_data), .tx_sym_valid(tx_sym_valid), .tx_sym_code(tx_sym_code),
        .tx_sym_data(tx_sym_data), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    xm_monitor xm_monitor_i (.pclk(pclk), .presetn(presetn), .tx_clk(link.tx_clk), .tx_ctl(link.tx_ctl),
        .tx_d(link.tx_d), .rx_clk(link.rx_clk), .rx_ctl(link.rx_ctl), .rx_d(link.rx_d), .stx_p(link.stx_p),
        .stx_n(link.stx_n), .srx_p(link.srx_p), .srx_n(link.srx_n));
    ////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic dreg(input logic w, input logic [15:0] a, input logic [15:0] d);
        reg_sel <= 1'b1;
        reg_wr <= w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge pclk);
        reg_sel <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_sym(input logic [3:0] d, input logic [1:0] c);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (!(tx_sym_valid === 1'b1 && tx_sym_data === d) && n < 400);
        if (n >= 400) miscompares++;
        chk("sym_data", 32'(d), 32'(tx_sym_data));
        chk("sym_code", 32'(c), 32'(tx_sym_code));
    endtask
    ////////
    task automatic t_regs;
        dreg(1'b0, xm_pkg::SMLC_ADDR, 16'h0);
        chk("cfg_reset", 32'(xm_pkg::SMLC_RESET), 32'(reg_rdata));
        dreg(1'b1, xm_pkg::SMLC_ADDR, 16'h0);
        dreg(1'b0, xm_pkg::SMLC_ADDR, 16'h0);
        chk("cfg_clear", 32'h0, 32'(reg_rdata));
        apb(1'b0, xm_pkg::CTRL_OFF, 32'h0);
        chk("ctrl_reset", 32'h0, rd);
        apb(1'b0, 12'hff0, 32'h0);
        chk("unmapped_err", 32'h1, 32'(er));
    endtask
    task automatic t_tx_par;
        for (int c = 0; c < 3; c++) begin
            apb(1'b1, xm_pkg::TXSYM_OFF, 32'(c * 16 + 9 + c));
            if (c == 2) apb(1'b1, xm_pkg::TXSYM_OFF, 32'h3c);
            wait_sym(4'(9 + c), (c == 1) ? 2'h0 : 2'(c));
        end
        wait_sym(4'hc, 2'h3);
        apb(1'b0, xm_pkg::STATUS_OFF, 32'h0);
        chk("pend_clear", 32'h0, 32'(rd[0]));
    endtask
    task automatic t_rx_par;
        logic [5:0] v [5] = '{6'h25, 6'h3c, 6'h1e, 6'h07, 6'h03};
        logic [7:0] cnt;
        cnt = 8'h00;
        full_duplex <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            link_up <= (i == 3);
            line_speed <= (i == 4) ? 2'h1 : 2'h3;
            line_rx_code <= v[i][5:4];
            line_rx_data <= v[i][3:0];
            repeat (37) @(posedge pclk);
            apb(1'b0, xm_pkg::STATUS_OFF, 32'h0);
            if (i < 3) chk("rx_sym", 32'(v[i]), 32'(rd[9:4]));
            else chk("inband", {28'h0, 1'b1, (i == 3) ? 2'h2 : 2'h1, i == 3}, 32'(rd[13:10]));
            if (i == 1 || i == 2) chk("rx_count", 32'h5, 32'(8'(rd[23:16] - cnt)));
            cnt = rd[23:16];
        end
    endtask
    task automatic t_serial;
        @(negedge link.rx_clk);
        @(posedge pclk);
        mode_serial <= 1'b1;
        @(negedge link.tx_clk);
        @(posedge pclk);
        apb(1'b1, xm_pkg::CTRL_OFF, 32'h1);
        repeat (200) @(posedge pclk);
        apb(1'b0, xm_pkg::STATUS_OFF, 32'h0);
        chk("lc_off", 32'h0, 32'(rd[14]));
        chk("par_quiet", 32'h0, {30'h0, link.tx_clk, link.rx_clk});
        dreg(1'b1, xm_pkg::SMLC_ADDR, 16'h1);
        repeat (200) @(posedge pclk);
        apb(1'b0, xm_pkg::STATUS_OFF, 32'h0);
        chk("lc_on", 32'h1, 32'(rd[14]));
        chk("lc_inband", 32'ha, 32'(rd[13:10]));
        apb(1'b1, xm_pkg::TXSYM_OFF, 32'h26);
        wait_sym(4'h6, 2'h2);
    endtask
    task automatic end_sim;
        if (miscompares == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        #100000;
        miscompares++;
        end_sim;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, mode_serial, link_up, full_duplex} = '0;
        {line_speed, line_rx_code, line_rx_data, reg_sel, reg_wr, reg_addr, reg_wdata} = '0;
        miscompares = 0;
        checked = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_tx_par;
        t_rx_par;
        t_serial;
        end_sim;
    end
endmodule
